// ---- substrate_shutter.sv ----
`timescale 1ns/100ps
module substrate_shutter #(
  parameter int PIX_W = 14,
  parameter int CNT_W = 13
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        field_start,
  input  wire logic        line_start,
  input  wire logic        gate_line,
  input  wire logic [13:0] pixel_pos,
  input  wire logic        gate_request,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             substrate_clear_pulse,
  output logic             vertical_sense_gate
);
  initial
  begin
    if (PIX_W != 14 || CNT_W != 13)
      $error("substrate_shutter supports only 14-bit pixels and 13-bit counts");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [12:0] exposure_field_count_q, substrate_mask_field_count_q;
  logic [12:0] substrate_pulses_per_field_q, substrate_start_line_delay_q;
  logic        skip_first_mask_q, gate_suppress_enable_q, substrate_start_polarity_q;
  logic [13:0] substrate_toggle_first_q, substrate_toggle_second_q;
  logic [13:0] fine_pulse_toggle_first_q, fine_pulse_toggle_second_q;
  logic        fine_first_on_field_q, fine_second_on_field_q;
  logic [12:0] primary_max_q;
  logic [2:0]  action_q;
  logic        action_strobe_q;
  logic [31:0] awaddr_q, wdata_q;
  logic        aw_held_q, w_held_q;
  logic        wr_go;
  logic        wr_hit;

  assign awready = !aw_held_q && !bvalid;
  assign wready  = !w_held_q && !bvalid;
  assign wr_go   = (aw_held_q || awvalid) && (w_held_q || wvalid) && !bvalid;

  function automatic logic [7:0] word_addr(input logic [31:0] a);
    word_addr = a[9:2];
  endfunction : word_addr

  function automatic logic known_addr(input logic [7:0] w);
    known_addr = (w == shutter_pkg::ADDR_MASK) || (w == shutter_pkg::ADDR_NUM)
              || (w == shutter_pkg::ADDR_CTRL) || (w == shutter_pkg::ADDR_TOG)
              || (w == shutter_pkg::ADDR_FINE) || (w == shutter_pkg::ADDR_ACTION)
              || (w == shutter_pkg::ADDR_STATUS);
  endfunction : known_addr

  logic [31:0] wa, wd;
  assign wa     = aw_held_q ? awaddr_q : awaddr;
  assign wd     = w_held_q ? wdata_q : wdata;
  assign wr_hit = known_addr(word_addr(wa)) && (wa[31:10] == 22'h000000);

  // Address and data may arrive in either order; hold each until both are here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 32'h0;
      wdata_q   <= 32'h0;
      bvalid    <= 1'b0;
      bresp     <= shutter_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? shutter_pkg::RESP_OKAY : shutter_pkg::RESP_SLVERR;
      end
      else
      begin
        if (awvalid && awready)
        begin
          aw_held_q <= 1'b1;
          awaddr_q  <= awaddr;
        end
        if (wvalid && wready)
        begin
          w_held_q <= 1'b1;
          wdata_q  <= wdata;
        end
        if (bvalid && bready)
          bvalid <= 1'b0;
      end
    end
  end

  // Register writes; no per-lane strobes: whole words only, with all four strobes set or the data held, for simplicity
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exposure_field_count_q       <= 13'h0;
      substrate_mask_field_count_q <= 13'h0;
      substrate_pulses_per_field_q <= shutter_pkg::NUM_RESET;
      substrate_start_line_delay_q <= 13'h0;
      skip_first_mask_q            <= 1'b0;
      gate_suppress_enable_q       <= 1'b0;
      substrate_start_polarity_q   <= 1'b0;
      fine_first_on_field_q        <= 1'b0;
      fine_second_on_field_q       <= 1'b0;
      substrate_toggle_first_q     <= 14'h0;
      substrate_toggle_second_q    <= 14'h0;
      fine_pulse_toggle_first_q    <= shutter_pkg::FINE_OFF;
      fine_pulse_toggle_second_q   <= shutter_pkg::FINE_OFF;
      primary_max_q                <= 13'h0001;
      action_q                     <= shutter_pkg::ACT_IDLE;
      action_strobe_q              <= 1'b0;
    end
    else
    begin
      action_strobe_q <= 1'b0;
      if (wr_go && wr_hit && (wstrb == 4'hF || w_held_q))
      begin
        case (word_addr(wa))
          shutter_pkg::ADDR_MASK:
          begin
            exposure_field_count_q       <= wd[12:0];
            substrate_mask_field_count_q <= wd[shutter_pkg::MASK_HI_LSB +: 13];
          end
          shutter_pkg::ADDR_NUM:
            if (wd[12:0] != 13'h0)
              substrate_pulses_per_field_q <= wd[12:0];
          shutter_pkg::ADDR_CTRL:
          begin
            substrate_start_line_delay_q <= wd[12:0];
            skip_first_mask_q            <= wd[16];
            gate_suppress_enable_q       <= wd[17];
            substrate_start_polarity_q   <= wd[18];
            fine_first_on_field_q        <= wd[19];
            fine_second_on_field_q       <= wd[20];
          end
          shutter_pkg::ADDR_TOG:
          begin
            substrate_toggle_first_q  <= wd[13:0];
            substrate_toggle_second_q <= wd[shutter_pkg::TOG2_LSB +: 14];
          end
          shutter_pkg::ADDR_FINE:
          begin
            fine_pulse_toggle_first_q  <= wd[13:0];
            fine_pulse_toggle_second_q <= wd[shutter_pkg::TOG2_LSB +: 14];
          end
          shutter_pkg::ADDR_ACTION:
          begin
            action_q        <= wd[2:0];
            primary_max_q   <= wd[16 +: 13];
            action_strobe_q <= 1'b1;
          end
          default:
            action_strobe_q <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary field counter; the secondary counter is not modelled at all
  shutter_pkg::pc_state_t pc_q;
  logic [12:0] field_cnt_q, gate_mask_q, sub_mask_q;
  logic        skip_pend_q;

  // Counter advances on each field boundary while running
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_q        <= shutter_pkg::PC_IDLE;
      field_cnt_q <= 13'h0;
      gate_mask_q <= 13'h0;
      sub_mask_q  <= 13'h0;
      skip_pend_q <= 1'b0;
    end
    else if (action_strobe_q)
    begin
      case (action_q)
        shutter_pkg::ACT_ONCE:   pc_q <= shutter_pkg::PC_ARMED;
        shutter_pkg::ACT_EXPOSE: pc_q <= shutter_pkg::PC_MANUAL;
        shutter_pkg::ACT_READ:
        begin
          pc_q        <= shutter_pkg::PC_RUN;
          gate_mask_q <= 13'h0;
        end
        default:                 pc_q <= shutter_pkg::PC_IDLE;
      endcase
      field_cnt_q <= 13'h0;
      skip_pend_q <= skip_first_mask_q;
    end
    else if (field_start)
    begin
      case (pc_q)
        shutter_pkg::PC_ARMED:
        begin
          pc_q        <= shutter_pkg::PC_RUN;
          field_cnt_q <= 13'h1;
          // Zero counts leave the outputs untouched
          gate_mask_q <= exposure_field_count_q;
          sub_mask_q  <= substrate_mask_field_count_q;
        end
        shutter_pkg::PC_RUN:
        begin
          field_cnt_q <= field_cnt_q + 13'h1;
          if (field_cnt_q >= primary_max_q)
            pc_q <= shutter_pkg::PC_IDLE;
          if (skip_pend_q)
            skip_pend_q <= 1'b0;
          else
          begin
            if (gate_mask_q != 13'h0)
              gate_mask_q <= gate_mask_q - 13'h1;
            if (sub_mask_q != 13'h0)
              sub_mask_q <= sub_mask_q - 13'h1;
          end
        end
        default:
          field_cnt_q <= field_cnt_q;
      endcase
    end
  end

  logic gate_masked, sub_masked;
  assign gate_masked = (pc_q == shutter_pkg::PC_MANUAL)
                    || (pc_q == shutter_pkg::PC_RUN && !skip_pend_q && gate_mask_q != 13'h0);
  assign sub_masked  = (pc_q == shutter_pkg::PC_MANUAL)
                    || (pc_q == shutter_pkg::PC_RUN && !skip_pend_q && sub_mask_q != 13'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Line sequencing of the substrate pulse train
  shutter_pkg::sub_cfg_t cfg_q;
  logic [13:0] fine1_q, fine2_q;
  logic        after_gate_q, run_q;
  logic [12:0] wait_q, left_q;
  logic        last_line;

  // Shadow copies refresh at the line after the gate line; fine copies at the field edge if their on-field bit is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q        <= '0;
      fine1_q      <= shutter_pkg::FINE_OFF;
      fine2_q      <= shutter_pkg::FINE_OFF;
      after_gate_q <= 1'b0;
    end
    else
    begin
      if (line_start)
        after_gate_q <= gate_line;
      if (line_start && after_gate_q)
      begin
        cfg_q <= '{substrate_start_polarity_q, substrate_toggle_first_q, substrate_toggle_second_q,
                   substrate_pulses_per_field_q, substrate_start_line_delay_q};
        if (!fine_first_on_field_q)
          fine1_q <= fine_pulse_toggle_first_q;
        if (!fine_second_on_field_q)
          fine2_q <= fine_pulse_toggle_second_q;
      end
      if (field_start && fine_first_on_field_q)
        fine1_q <= fine_pulse_toggle_first_q;
      if (field_start && fine_second_on_field_q)
        fine2_q <= fine_pulse_toggle_second_q;
    end
  end

  // Count delay lines, then one pulse per line until the count runs out
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q  <= 1'b0;
      wait_q <= 13'h0;
      left_q <= 13'h0;
    end
    else if (field_start)
      run_q <= 1'b0;
    else if (line_start && after_gate_q)
    begin
      run_q  <= 1'b1;
      wait_q <= substrate_start_line_delay_q;
      left_q <= substrate_pulses_per_field_q;
    end
    else if (line_start && run_q)
    begin
      if (wait_q != 13'h0)
        wait_q <= wait_q - 13'h1;
      else if (left_q != 13'h0)
        left_q <= left_q - 13'h1;
    end
  end

  assign last_line = run_q && wait_q == 13'h0 && left_q == 13'h1;

  function automatic logic in_window(input logic [13:0] p, a, b);
    in_window = (p >= a) && (p < b);
  endfunction : in_window

  // Pixel index lags one cycle to line up with the line counters, which move on
  // the line_start edge; otherwise pixel 0 would be judged against the old line
  logic [13:0] pixel_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pixel_q <= 14'h0;
    else
      pixel_q <= pixel_pos;
  end

  logic pulse_now, fine_now;
  assign pulse_now = run_q && wait_q == 13'h0 && left_q != 13'h0
                  && in_window(pixel_q, cfg_q.tog1, cfg_q.tog2);
  // Maximum value never matches a pixel window, so no extra pulse
  assign fine_now  = last_line && fine1_q != shutter_pkg::FINE_OFF
                  && in_window(pixel_q, fine1_q, fine2_q);

  // Outputs from flops; masking comes from the primary counter, and the gate also from the suppress bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      substrate_clear_pulse <= 1'b0;
      vertical_sense_gate   <= 1'b0;
    end
    else
    begin
      substrate_clear_pulse <= cfg_q.pol ^ ((pulse_now || fine_now) && !sub_masked);
      vertical_sense_gate   <= gate_request && !gate_masked && !gate_suppress_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel, one-cycle answer
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0;
    case (word_addr(araddr))
      shutter_pkg::ADDR_MASK:   rd_val = {3'h0, substrate_mask_field_count_q, 3'h0, exposure_field_count_q};
      shutter_pkg::ADDR_NUM:    rd_val = {19'h0, substrate_pulses_per_field_q};
      shutter_pkg::ADDR_CTRL:   rd_val = {11'h0, fine_second_on_field_q, fine_first_on_field_q,
                                          substrate_start_polarity_q, gate_suppress_enable_q,
                                          skip_first_mask_q, 3'h0, substrate_start_line_delay_q};
      shutter_pkg::ADDR_TOG:    rd_val = {2'h0, substrate_toggle_second_q, 2'h0, substrate_toggle_first_q};
      shutter_pkg::ADDR_FINE:   rd_val = {2'h0, fine_pulse_toggle_second_q, 2'h0, fine_pulse_toggle_first_q};
      shutter_pkg::ADDR_ACTION: rd_val = {3'h0, primary_max_q, 13'h0, action_q};
      shutter_pkg::ADDR_STATUS: rd_val = {pc_q, 2'h0, sub_masked, gate_masked, 11'h0, field_cnt_q};
      default:                  rd_val = 32'h0;
    endcase
  end

  assign arready = !rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= shutter_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= (known_addr(word_addr(araddr)) && araddr[31:10] == 22'h0)
                ? shutter_pkg::RESP_OKAY : shutter_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_gate_then_line;
    line_start && after_gate_q && !field_start;
  endsequence

  a_pulse_load: assert property (@(posedge aclk) disable iff (!aresetn)
    s_gate_then_line |=> run_q && left_q == $past(substrate_pulses_per_field_q))
    else $error("pulse count not loaded");
  a_cfg_update: assert property (@(posedge aclk) disable iff (!aresetn)
    !(line_start && after_gate_q) |=> $stable(cfg_q))
    else $error("settings changed outside gate line");
  a_mask_sub: assert property (@(posedge aclk) disable iff (!aresetn)
    sub_masked |=> !substrate_clear_pulse == !cfg_q.pol || $past(cfg_q.pol) != cfg_q.pol)
    else $error("substrate pulse while masked");
  a_gate_supp: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_suppress_enable_q |=> !vertical_sense_gate)
    else $error("gate while suppressed");
  a_gate_default: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_request && pc_q == shutter_pkg::PC_IDLE && !gate_suppress_enable_q |=> vertical_sense_gate)
    else $error("gate missing by default");
  a_manual_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_q == shutter_pkg::PC_MANUAL |-> gate_masked && sub_masked)
    else $error("manual exposure not masking");
  a_fine_off: assert property (@(posedge aclk) disable iff (!aresetn)
    fine1_q == shutter_pkg::FINE_OFF |-> !fine_now)
    else $error("extra pulse while disabled");
  a_field_adv: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start && pc_q == shutter_pkg::PC_RUN && !action_strobe_q
    |=> field_cnt_q == $past(field_cnt_q) + 13'h1)
    else $error("counter did not advance");
endmodule : substrate_shutter

// ---- shutter_pkg.sv ----
package shutter_pkg;
  localparam logic [7:0]  ADDR_MASK    = 8'h74; // Both mask counts
  localparam logic [7:0]  ADDR_NUM     = 8'h75; // Pulses per field
  localparam logic [7:0]  ADDR_CTRL    = 8'h76;
  localparam logic [7:0]  ADDR_TOG     = 8'h77;
  localparam logic [7:0]  ADDR_FINE    = 8'h78;
  localparam logic [7:0]  ADDR_ACTION  = 8'h70;
  localparam logic [7:0]  ADDR_STATUS  = 8'h79;
  localparam int          MASK_HI_LSB  = 16;
  localparam int          TOG2_LSB     = 16;
  localparam logic [13:0] FINE_OFF     = 14'h3FFF; // Field maximum, extra pulse off
  localparam logic [12:0] NUM_RESET    = 13'h0001;
  localparam logic [2:0]  ACT_IDLE     = 3'h0;
  localparam logic [2:0]  ACT_ONCE     = 3'h1;
  localparam logic [2:0]  ACT_EXPOSE   = 3'h5;
  localparam logic [2:0]  ACT_READ     = 3'h6;
  localparam logic [2:0]  ACT_FORCE    = 3'h7;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [3:0] {
    PC_IDLE   = 4'b0001,
    PC_ARMED  = 4'b0010,
    PC_RUN    = 4'b0100,
    PC_MANUAL = 4'b1000
  } pc_state_t;

  // Line-locked shadow copy of the substrate settings
  typedef struct packed {
    logic        pol;
    logic [13:0] tog1;
    logic [13:0] tog2;
    logic [12:0] num;
    logic [12:0] delay;
  } sub_cfg_t;
endpackage : shutter_pkg

// ---- ccd_sensor_model.sv ----
`timescale 1ns/100ps
module ccd_sensor_model (
  input  wire logic aclk,
  input  wire logic field_start,
  input  wire logic line_start,
  input  wire logic substrate_clear_pulse,
  input  wire logic vertical_sense_gate,
  output int        sub_starts,
  output int        sub_hi,
  output int        first_line,
  output int        gate_starts
);
  logic idle_q;
  logic sub_q;
  logic gate_q;
  int   line_q;
  logic active;

  // Idle substrate level is taken at the field edge, so either start polarity reads right
  assign active = (substrate_clear_pulse !== idle_q);

  //////////////////////////////////////////////////////////////////////////////
  // Per-field tally of charge clears and transfers, as the sensor sees them
  always_ff @(posedge aclk)
  begin
    gate_q <= vertical_sense_gate;
    if (field_start)
    begin
      idle_q      <= substrate_clear_pulse;
      sub_q       <= 1'b0;
      line_q      <= 0;
      sub_starts  <= 0;
      sub_hi      <= 0;
      first_line  <= -1;
      gate_starts <= 0;
    end
    else
    begin
      sub_q <= active;
      if (line_start)
        line_q <= line_q + 1;
      if (active)
        sub_hi <= sub_hi + 1;
      if (active && !sub_q)
        sub_starts <= sub_starts + 1;
      if (active && !sub_q && first_line < 0)
        first_line <= line_q;
      if (vertical_sense_gate && !gate_q)
        gate_starts <= gate_starts + 1;
    end
  end
endmodule : ccd_sensor_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  localparam int LINES = 16;
  localparam int PIX   = 32;
  typedef struct {int num; int t1; int t2; int pol; int dly; int f1; int f2;} row_t;

  logic        aclk, aresetn, field_start, line_start, gate_line, gate_request;
  logic [13:0] pixel_pos;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        substrate_clear_pulse, vertical_sense_gate;
  int          sub_starts, sub_hi, first_line, gate_starts, cur_line;
  int          checks, mismatches;
  row_t        rows[5] = '{'{1, 4, 10, 0, 0, 16383, 16383}, '{5, 0, 31, 0, 3, 16383, 16383},
                           '{13, 4, 10, 1, 0, 16383, 16383}, '{3, 4, 10, 0, 0, 20, 24},
                           '{2, 8, 9, 1, 7, 16383, 16383}};

  substrate_shutter dut_u (.aclk, .aresetn, .field_start, .line_start, .gate_line, .pixel_pos,
    .gate_request, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .substrate_clear_pulse,
    .vertical_sense_gate);

  ccd_sensor_model sensor_u (.aclk, .field_start, .line_start, .substrate_clear_pulse,
    .vertical_sense_gate, .sub_starts, .sub_hi, .first_line, .gate_starts);

  //////////////////////////////////////////////////////////////////////////////
  // Clock generation
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare and report helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // A handshake that never completes ends the run rather than hanging it
  task automatic hung();
    mismatches++;
    $display("[ERR] handshake expected within bound seen none");
    finish_test();
  endtask : hung

  //////////////////////////////////////////////////////////////////////////////
  // Register bus master: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr  <= {22'h000000, idx, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 64);
    if (n >= 64)
      hung();
    bready <= 1'b0;
    chk("bresp", bresp, shutter_pkg::RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [1:0] exp_resp);
    int n;
    @(posedge aclk);
    araddr  <= {22'h000000, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 64);
    if (n >= 64)
      hung();
    rd_q = rdata;
    rready <= 1'b0;
    chk("rresp", rresp, exp_resp);
  endtask : rd

  //////////////////////////////////////////////////////////////////////////////
  // One field of line timing; line 1 is the gate line, the extra pass is an idle tail
  task automatic run_field();
    for (int l = 0; l <= LINES; l++)
      for (int p = 0; p < PIX; p++)
      begin
        @(posedge aclk);
        field_start  <= (l == 0 && p == 0);
        line_start   <= (p == 0 && l < LINES);
        gate_line    <= (l == 1);
        pixel_pos    <= 14'(p);
        gate_request <= (l == 1 && p >= 2 && p < 6);
        cur_line = l;
      end
  endtask : run_field

  task automatic cfg(input row_t r, input logic [31:0] ctl);
    wr(shutter_pkg::ADDR_NUM, 32'(r.num));
    wr(shutter_pkg::ADDR_CTRL, ctl | 32'(r.dly) | 32'(r.pol << 18));
    wr(shutter_pkg::ADDR_TOG, 32'(r.t1 | (r.t2 << 16)));
    wr(shutter_pkg::ADDR_FINE, 32'(r.f1 | (r.f2 << 16)));
  endtask : cfg

  // Register write landing in the given line of a running field
  task automatic mid(input int line, input logic [7:0] idx, input logic [31:0] d);
    cur_line = 0;
    fork
      run_field();
      begin
        for (int i = 0; i < 2000 && cur_line < line; i++)
          @(posedge aclk);
        if (cur_line < line)
          hung();
        wr(idx, d);
      end
    join
  endtask : mid

  // Fields in a row; a set bit means that output is expected to be masked
  task automatic seq(input int n, input logic [7:0] gm, input logic [7:0] sm, input int num);
    for (int i = 0; i < n; i++)
    begin
      run_field();
      chk("gate_starts", gate_starts, gm[i] ? 0 : 1);
      chk("sub_starts", sub_starts, sm[i] ? 0 : num);
    end
  endtask : seq

  function automatic logic [31:0] act(input logic [2:0] code);
    return {16'h0008, 13'h0000, code};
  endfunction : act

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of line configurations, then the awkward cases
  initial
  begin
    {aresetn, field_start, line_start, gate_line, gate_request, pixel_pos} = '0;
    {awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    cur_line = 0;
    repeat (8) @(posedge aclk);
    chk("sub_in_reset", substrate_clear_pulse, 1'b0);
    chk("gate_in_reset", vertical_sense_gate, 1'b0);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(shutter_pkg::ADDR_CTRL, shutter_pkg::RESP_OKAY);
    chk("skip_reset", rd_q[16], 1'b0);
    rd(shutter_pkg::ADDR_FINE, shutter_pkg::RESP_OKAY);
    chk("fine_reset", rd_q, 32'h3FFF3FFF);
    rd(8'h7F, shutter_pkg::RESP_SLVERR);
    chk("unmapped_data", rd_q, 32'h00000000);
    run_field();
    chk("gate_default", gate_starts, 1);
    $display("reset test done");
    foreach (rows[i])
    begin
      cfg(rows[i], 32'h00000000);
      run_field();
      run_field();
      chk("sub_starts", sub_starts, rows[i].num + (rows[i].f1 != 16383));
      chk("sub_hi", sub_hi, rows[i].num * (rows[i].t2 - rows[i].t1) +
          (rows[i].f1 != 16383) * (rows[i].f2 - rows[i].f1));
      chk("first_line", first_line, 2 + rows[i].dly);
      $display("row %0d done", i);
    end
    rd(shutter_pkg::ADDR_TOG, shutter_pkg::RESP_OKAY);
    chk("tog_readback", rd_q, 32'h00090008);
    cfg(rows[0], 32'h00000000);
    run_field();
    mid(4, shutter_pkg::ADDR_NUM, 32'h00000004);
    chk("late_count", sub_starts, 1);
    run_field();
    chk("new_count", sub_starts, 4);
    wr(shutter_pkg::ADDR_NUM, 32'h00000000);
    run_field();
    chk("zero_count", sub_starts, 4);
    $display("update test done");
    cfg(rows[0], 32'h00180000);
    run_field();
    mid(0, shutter_pkg::ADDR_FINE, 32'h00180014);
    chk("fine_at_field", sub_starts, 1);
    run_field();
    chk("fine_next", sub_starts, 2);
    cfg(rows[0], 32'h00020000);
    seq(2, 8'h03, 8'h00, 1);
    $display("fine and suppress tests done");
    cfg(rows[0], 32'h00000000);
    wr(shutter_pkg::ADDR_MASK, 32'h00030002);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_ONCE));
    seq(4, 8'h03, 8'h07, 1);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_FORCE));
    cfg(rows[0], 32'h00010000);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_ONCE));
    seq(5, 8'h06, 8'h0E, 1);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_FORCE));
    cfg(rows[0], 32'h00000000);
    wr(shutter_pkg::ADDR_MASK, 32'h00000000);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_ONCE));
    seq(2, 8'h00, 8'h00, 1);
    repeat (6) run_field();
    rd(shutter_pkg::ADDR_STATUS, shutter_pkg::RESP_OKAY);
    chk("once_running", rd_q[31:28], shutter_pkg::PC_RUN);
    run_field();
    rd(shutter_pkg::ADDR_STATUS, shutter_pkg::RESP_OKAY);
    chk("once_idle", rd_q[31:28], shutter_pkg::PC_IDLE);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_FORCE));
    wr(shutter_pkg::ADDR_MASK, 32'h00030002);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_EXPOSE));
    seq(3, 8'h07, 8'h07, 1);
    wr(shutter_pkg::ADDR_ACTION, act(shutter_pkg::ACT_READ));
    run_field();
    chk("gate_readout", gate_starts, 1);
    $display("long exposure tests done");
    finish_test();
  end
endmodule : tb
